// [verilog/bus_pins_consts.svh]
// constants for the external memory bus pin controller
// assumes inclusion by bare name from design files only
`ifndef BUS_PINS_CONSTS_SVH
`define BUS_PINS_CONSTS_SVH
`define AREA_HI 28
`define AREA_LO 26
`define HALF_BIT 25
`define BANK_HI 25
`define BANK_LO 23
`define BEAT_STEP 26'h0000004
`define AREA0 3'h0
`define AREA2 3'h2
`define AREA3 3'h3
`define AREA4 3'h4
`define AREA5 3'h5
`define AREA6 3'h6
`define LANES_IDLE 4'hF
`define BANKS_IDLE 8'hFF
`endif

// [verilog/bus_pins_pkg.sv]
// types shared by the bus pin controller modules
// assumes the constants header is included where needed
package bus_pins_pkg;
  typedef enum logic [1:0] {MEM_ORDINARY, MEM_BURST_ROM, MEM_SDRAM, MEM_PCMCIA} mem_kind_type;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_DONE, ST_REL_OFF, ST_REL, ST_REL_END} state_type;
endpackage : bus_pins_pkg

// [verilog/cycle_if.sv]
// carrier between cycle sequencer and lane strobe decoder
// assumes one clock domain, no timing inside
`timescale 1ns/100ps
`default_nettype none
interface cycle_if;
  import bus_pins_pkg::*;
  mem_kind_type kind;
  logic write;
  logic io;
  logic [3:0] be;
  logic active;
  logic [3:0] lanes_n;
  modport ctrl (output kind, output write, output io, output be, output active, input lanes_n);
  modport dec (input kind, input write, input io, input be, input active, output lanes_n);
endinterface : cycle_if
`default_nettype wire

// [verilog/lane_strobe_decode.sv]
// byte lane strobe decoder, role depends on memory kind
// assumes inputs are registered cycle state from the sequencer
`timescale 1ns/100ps
`default_nettype none
`include "bus_pins_consts.svh"
module lane_strobe_decode (
  cycle_if.dec c
);
  import bus_pins_pkg::*;
  wire logic [3:0] wr_lanes_n;
  wire logic [3:0] mask_lanes;
  wire logic [3:0] card_lanes_n;
  // write strobes per lane for ordinary and rom
  assign wr_lanes_n = ~({4{c.active & c.write}} & c.be);
  // sdram masks: high masks a lane, idle masks all
  assign mask_lanes = c.active ? ~c.be : `LANES_IDLE;
  // card: lane1 memory write, lane2 io read, lane3 io write
  assign card_lanes_n = {~(c.active & c.io & c.write),
                         ~(c.active & c.io & ~c.write),
                         ~(c.active & ~c.io & c.write),
                         wr_lanes_n[0]};
  assign c.lanes_n = (c.kind == MEM_SDRAM) ? mask_lanes :
                     (c.kind == MEM_PCMCIA) ? card_lanes_n : wr_lanes_n;
endmodule : lane_strobe_decode
`default_nettype wire

// [verilog/external_memory_bus_pins.sv]
// external bus pin controller: sequences cycles onto pins
// assumes synchronous pin inputs and a one-cycle request port
`timescale 1ns/100ps
`default_nettype none
`include "bus_pins_consts.svh"
module external_memory_bus_pins (
  input wire logic clk,
  input wire logic rst_n,
  // on-chip request side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [28:0] req_addr,
  input wire logic req_write,
  input wire logic req_io,
  input wire logic [3:0] req_be,
  input wire logic [31:0] req_wdata,
  input wire logic [1:0] req_extra_beats,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  // area configuration
  input wire logic [6:0] area_wide,
  input wire logic area0_burst_rom,
  input wire logic area2_sdram,
  input wire logic area3_sdram,
  input wire logic area5_pcmcia,
  input wire logic area6_pcmcia,
  input wire logic [1:0] rom_bank_enable,
  input wire logic little_endian,
  input wire logic sdram_clock_stop,
  // pins
  output logic [25:0] addr_out,
  output logic addr_oe,
  output logic [31:0] data_out,
  input wire logic [31:0] data_in,
  output logic data_oe_lo,
  output logic data_oe_hi,
  output logic strobe_oe,
  output logic cycle_start_out_n,
  output logic area0_select_n,
  output logic [2:0] area2_to_4_select_n,
  output logic area5_select_or_slot_a_enable1_n,
  output logic area6_select_or_slot_b_enable1_n,
  output logic slot_a_enable2_n,
  output logic slot_b_enable2_n,
  output logic rd_wr,
  output logic read_strobe_n,
  output logic row_strobe_low_half_n,
  output logic row_strobe_high_half_n,
  output logic column_strobe_low_half_n,
  output logic column_strobe_high_half_n,
  output logic lane0_strobe_n,
  output logic lane1_strobe_n,
  output logic lane2_strobe_n,
  output logic lane3_strobe_n,
  input wire logic wait_n,
  output logic sdram_clock_enable,
  input wire logic io16_n,
  input wire logic bus_release_request_n,
  output logic bus_release_ack_n,
  output logic [7:0] rom_bank_selects_n
);
  import bus_pins_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decoding functions

  function automatic mem_kind_type kind_of(input logic [2:0] area, input logic b0, input logic s2,
                                           input logic s3, input logic p5, input logic p6);
    kind_of = MEM_ORDINARY;
    case (area)
      `AREA0: if (b0) kind_of = MEM_BURST_ROM;
      `AREA2: if (s2) kind_of = MEM_SDRAM;
      `AREA3: if (s3) kind_of = MEM_SDRAM;
      `AREA5: if (p5) kind_of = MEM_PCMCIA;
      `AREA6: if (p6) kind_of = MEM_PCMCIA;
      default: kind_of = MEM_ORDINARY;
    endcase
  endfunction : kind_of

  function automatic logic area_hit(input logic [2:0] area, input logic [2:0] want);
    area_hit = (area == want);
  endfunction : area_hit

  ////////////////////////////////////////////////////////////////////////////
  // registers

  state_type state_r, state_nxt;
  logic [28:0] addr_r, addr_nxt;
  logic write_r, write_nxt;
  logic io_r, io_nxt;
  logic [3:0] be_r, be_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [1:0] beats_r, beats_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rsp_r, rsp_nxt;

  cycle_if lanes_bus ();

  wire logic [2:0] cur_area;
  wire mem_kind_type cur_kind;
  wire logic cur_wide;
  wire logic narrow_io;
  wire logic in_cycle;
  wire logic released;
  wire logic last_beat;
  wire logic [31:0] rdata_lanes;
  wire logic [7:0] bank_dec_n;
  wire logic rom_area;

  assign cur_area = addr_r[`AREA_HI:`AREA_LO];
  assign cur_kind = kind_of(cur_area, area0_burst_rom, area2_sdram, area3_sdram, area5_pcmcia, area6_pcmcia);
  // card io port flagged 16-bit only counts in little-endian mode
  assign narrow_io = (cur_kind == MEM_PCMCIA) && io_r && little_endian && !io16_n;
  assign cur_wide = area_wide[cur_area] && !narrow_io;
  assign in_cycle = (state_r == ST_START) || (state_r == ST_DATA);
  assign released = (state_r == ST_REL_OFF) || (state_r == ST_REL) || (state_r == ST_REL_END);
  assign last_beat = (beats_r == 2'h0);
  assign rdata_lanes = cur_wide ? data_in : {16'h0000, data_in[15:0]};

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    write_nxt = write_r;
    io_nxt = io_r;
    be_nxt = be_r;
    wdata_nxt = wdata_r;
    beats_nxt = beats_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (!bus_release_request_n) begin
          state_nxt = ST_REL_OFF;
        end else if (req_valid) begin
          addr_nxt = req_addr;
          write_nxt = req_write;
          io_nxt = req_io;
          be_nxt = req_be;
          wdata_nxt = req_wdata;
          beats_nxt = req_extra_beats;
          state_nxt = ST_START;
        end
      end
      ST_START: state_nxt = ST_DATA;
      ST_DATA: begin
        if (wait_n) begin
          rdata_nxt = rdata_lanes;
          if (last_beat) begin
            state_nxt = ST_DONE;
          end else begin
            beats_nxt = beats_r - 2'h1;
            addr_nxt = {addr_r[28:26], addr_r[25:0] + `BEAT_STEP};
            state_nxt = ST_START;
          end
        end
      end
      ST_DONE: begin
        rsp_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      // pins float one cycle before acknowledge appears
      ST_REL_OFF: state_nxt = ST_REL;
      ST_REL: if (bus_release_request_n) state_nxt = ST_REL_END;
      // acknowledge negated one cycle before pins drive again
      ST_REL_END: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      addr_r <= 29'h00000000;
      write_r <= 1'b0;
      io_r <= 1'b0;
      be_r <= 4'h0;
      wdata_r <= 32'h00000000;
      beats_r <= 2'h0;
      rdata_r <= 32'h00000000;
      rsp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      write_r <= write_nxt;
      io_r <= io_nxt;
      be_r <= be_nxt;
      wdata_r <= wdata_nxt;
      beats_r <= beats_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign req_ready = (state_r == ST_IDLE) && bus_release_request_n;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  assign addr_out = addr_r[25:0];
  assign addr_oe = !released;
  assign strobe_oe = !released;
  assign data_out = wdata_r;
  assign data_oe_lo = in_cycle && write_r;
  assign data_oe_hi = in_cycle && write_r && cur_wide;
  assign cycle_start_out_n = !(state_r == ST_START);
  assign rd_wr = !(in_cycle && write_r);
  assign read_strobe_n = !((state_r == ST_DATA) && !write_r);
  assign sdram_clock_enable = !sdram_clock_stop;

  // area selects, one low at a time, only during a cycle
  assign area0_select_n = !(in_cycle && area_hit(cur_area, `AREA0));
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_mid_sel
      assign area2_to_4_select_n[g] = !(in_cycle && area_hit(cur_area, `AREA2 + 3'(g)));
    end
  endgenerate
  // same pins serve as card enable1 when card mode is on
  assign area5_select_or_slot_a_enable1_n = !(in_cycle && area_hit(cur_area, `AREA5));
  assign area6_select_or_slot_b_enable1_n = !(in_cycle && area_hit(cur_area, `AREA6));
  // enable2 for odd byte, card mode only
  assign slot_a_enable2_n = !(in_cycle && area5_pcmcia && area_hit(cur_area, `AREA5) && be_r[1]);
  assign slot_b_enable2_n = !(in_cycle && area6_pcmcia && area_hit(cur_area, `AREA6) && be_r[1]);

  // sdram strobes chosen by address half
  assign row_strobe_low_half_n = !((state_r == ST_START) && (cur_kind == MEM_SDRAM) && !addr_r[`HALF_BIT]);
  assign row_strobe_high_half_n = !((state_r == ST_START) && (cur_kind == MEM_SDRAM) && addr_r[`HALF_BIT]);
  assign column_strobe_low_half_n = !((state_r == ST_DATA) && (cur_kind == MEM_SDRAM) && !addr_r[`HALF_BIT]);
  assign column_strobe_high_half_n = !((state_r == ST_DATA) && (cur_kind == MEM_SDRAM) && addr_r[`HALF_BIT]);

  // rom bank selects within area 0 or 2
  assign rom_area = (area_hit(cur_area, `AREA0) && rom_bank_enable[0]) ||
                    (area_hit(cur_area, `AREA2) && rom_bank_enable[1]);
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bank
      assign bank_dec_n[g] = !(addr_r[`BANK_HI:`BANK_LO] == 3'(g));
    end
  endgenerate
  assign rom_bank_selects_n = (in_cycle && rom_area) ? bank_dec_n : `BANKS_IDLE;

  // byte lane strobes
  assign lanes_bus.kind = cur_kind;
  assign lanes_bus.write = write_r;
  assign lanes_bus.io = io_r;
  assign lanes_bus.be = cur_wide ? be_r : {2'h0, be_r[1:0]};
  assign lanes_bus.active = (state_r == ST_DATA);
  lane_strobe_decode u_lanes (
    .c(lanes_bus.dec)
  );
  assign lane0_strobe_n = lanes_bus.lanes_n[0];
  assign lane1_strobe_n = lanes_bus.lanes_n[1];
  assign lane2_strobe_n = lanes_bus.lanes_n[2];
  assign lane3_strobe_n = lanes_bus.lanes_n[3];

  assign bus_release_ack_n = !(state_r == ST_REL);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_wait_holds_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_DATA) && !wait_n |=> (state_r == ST_DATA) && cycle_start_out_n)
    else $error("wait did not hold the cycle");
  a_start_every_beat: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_DATA) && wait_n && !last_beat |=> !cycle_start_out_n ##1 cycle_start_out_n)
    else $error("missing cycle start on burst beat");
  a_one_select: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0(~{area0_select_n, area2_to_4_select_n, area5_select_or_slot_a_enable1_n,
               area6_select_or_slot_b_enable1_n}))
    else $error("more than one area select");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !in_cycle |-> area0_select_n && (&area2_to_4_select_n) && (&rom_bank_selects_n) &&
      lane0_strobe_n && lane1_strobe_n && read_strobe_n)
    else $error("select or strobe active outside cycle");
  a_release_float: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_release_ack_n |-> !addr_oe && !data_oe_lo && !strobe_oe && !$past(addr_oe))
    else $error("pins driven while bus released");
  a_ack_answer: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_IDLE) && !bus_release_request_n |=> bus_release_ack_n ##1 !bus_release_ack_n)
    else $error("release acknowledge not given in two cycles");
  a_upper_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    data_oe_hi |-> data_oe_lo && area_wide[cur_area])
    else $error("upper data driven on narrow area");
  a_row_half: assert property (@(posedge clk) disable iff (!rst_n)
    !row_strobe_low_half_n |-> !addr_r[`HALF_BIT] && row_strobe_high_half_n ##1 !column_strobe_low_half_n)
    else $error("low half strobe sequence wrong");
  a_enable2_card: assert property (@(posedge clk) disable iff (!rst_n)
    !slot_a_enable2_n || !slot_b_enable2_n |-> area5_pcmcia || area6_pcmcia)
    else $error("card enable2 outside card mode");
  a_read_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    !read_strobe_n |-> rd_wr && (!$past(cycle_start_out_n) || !$past(read_strobe_n)))
    else $error("read strobe without read cycle");
  a_io16_narrow: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_kind == MEM_PCMCIA) && io_r && little_endian && !io16_n |-> !data_oe_hi)
    else $error("upper data driven on 16-bit io port");
  a_enable2_pair: assert property (@(posedge clk) disable iff (!rst_n)
    !slot_a_enable2_n |-> !area5_select_or_slot_a_enable1_n)
    else $error("slot enable2 without enable1");
  a_card_io_write: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_kind == MEM_PCMCIA) && !lane3_strobe_n |-> io_r && write_r && (state_r == ST_DATA))
    else $error("card io write strobe outside io write");
endmodule : external_memory_bus_pins
`default_nettype wire

// [tb/ext_memory_model.sv]
// far-side memory model: byte-lane writes, read data, wait insertion
// assumes one clock and the pin timing of the bus pin controller
`timescale 1ns/100ps
`default_nettype none
module ext_memory_model (
  input wire logic clk,
  input wire logic [25:0] addr_out,
  input wire logic [31:0] data_out,
  input wire logic data_oe_hi,
  input wire logic rd_wr,
  input wire logic read_strobe_n,
  input wire logic [3:0] lanes_n,
  input wire logic [3:0] stall,
  output logic [31:0] data_in,
  output logic wait_n,
  output logic io16_n
);
  logic [31:0] mem [logic [23:0]];
  logic [31:0] last_r;
  logic [3:0] wcnt_r;
  wire [23:0] key = addr_out[25:2];
  ////////////////////////////////////////////////////////////////
  // read data only while strobed, changing pattern otherwise
  always_comb begin
    if (!read_strobe_n) begin
      data_in = mem.exists(key) ? mem[key] : 32'h0;
    end else begin
      data_in = ~last_r;
    end
  end
  assign wait_n = !(!read_strobe_n && wcnt_r < stall);
  // card flags 16-bit io ports at addresses with bit 10 set
  assign io16_n = !addr_out[10];
  always @(posedge clk) begin
    last_r <= data_in;
    wcnt_r <= read_strobe_n ? 4'h0 : wcnt_r + 4'h1;
    if (!rd_wr) begin
      if (!mem.exists(key)) begin
        mem[key] = 32'h0;
      end
      for (int k = 0; k < 4; k++) begin
        if (!lanes_n[k] && (k < 2 || data_oe_hi)) begin
          mem[key][8*k +: 8] = data_out[8*k +: 8];
        end
      end
    end
  end
endmodule : ext_memory_model
`default_nettype wire

// [tb/tb_external_memory_bus_pins.sv]
// self-checking bench for the external memory bus pin controller
// assumes the far-side model in ext_memory_model
`timescale 1ns/100ps
`default_nettype none
module tb_external_memory_bus_pins;
  logic clk, rst_n, req_valid, req_ready, req_write, req_io, rsp_valid, little_endian, sdram_clock_stop;
  logic [28:0] req_addr;
  logic [3:0] req_be, stall;
  logic [31:0] req_wdata, rsp_rdata, data_out, data_in;
  logic [1:0] req_extra_beats, rom_bank_enable;
  logic [6:0] area_wide;
  logic area0_burst_rom, area2_sdram, area3_sdram, area5_pcmcia, area6_pcmcia;
  logic [25:0] addr_out;
  logic addr_oe, data_oe_lo, data_oe_hi, strobe_oe, cycle_start_out_n, area0_select_n;
  logic [2:0] area2_to_4_select_n;
  logic area5_select_or_slot_a_enable1_n, area6_select_or_slot_b_enable1_n, slot_a_enable2_n, slot_b_enable2_n;
  logic rd_wr, read_strobe_n, row_strobe_low_half_n, row_strobe_high_half_n, column_strobe_low_half_n;
  logic column_strobe_high_half_n, lane0_strobe_n, lane1_strobe_n, lane2_strobe_n, lane3_strobe_n;
  logic wait_n, sdram_clock_enable, io16_n, bus_release_request_n, bus_release_ack_n;
  logic [7:0] rom_bank_selects_n;
  wire [3:0] lanes_n = {lane3_strobe_n, lane2_strobe_n, lane1_strobe_n, lane0_strobe_n};
  wire [5:0] sels_n = {area6_select_or_slot_b_enable1_n, area5_select_or_slot_a_enable1_n, area2_to_4_select_n,
    area0_select_n};
  typedef struct {logic chk; logic [31:0] d; int lat; int beats;} note_type;
  note_type notes[$];
  note_type n;
  logic [31:0] shadow [logic [23:0]];
  int err_count, num_checks, seed, cyc, starts;
  external_memory_bus_pins u_dut (.*);
  ext_memory_model u_mem (.*);
  ////////////////////////////////////////////////////////////////
  task automatic chk_pin(input string w, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask : chk_pin
  task automatic chk_data(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask : chk_data
  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  task automatic bus_op(input logic [2:0] ar, input logic [25:0] a, input logic wr, input logic io,
    input logic [3:0] be, input logic [1:0] ex, input logic [3:0] st);
    logic [31:0] wd, e;
    logic [23:0] k;
    int idx;
    logic card, rom;
    wd = $random(seed);
    k = a[25:2] + 24'(ex);
    idx = (ar == 3'h0) ? 0 : int'(ar) - 1;
    card = (ar == 3'h5) || (ar == 3'h6 && area6_pcmcia);
    rom = (ar == 3'h0 && rom_bank_enable[0]) || (ar == 3'h2 && rom_bank_enable[1]);
    e = shadow.exists(k) ? shadow[k] : 32'h0;
    if (!area_wide[ar]) e[31:16] = 16'h0;
    if (wr && !card) begin
      if (!shadow.exists(k)) shadow[k] = 32'h0;
      for (int i = 0; i < 4; i++) if (be[i] && (i < 2 || area_wide[ar])) shadow[k][8*i +: 8] = wd[8*i +: 8];
    end
    req_addr = {ar, a};
    req_write = wr;
    req_io = io;
    req_be = be;
    req_wdata = wd;
    req_extra_beats = ex;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(posedge clk) #2;
    @(posedge clk) #2;
    req_valid = 1'b0;
    stall = st;
    starts = 0;
    notes.push_back('{!wr && !card, e, cyc + 3 + 2 * ex + st * (ex + 1), ex + 1});
    chk_pin("selects", 6'(~(6'h1 << idx)), sels_n);
    chk_data("addr_out", a, addr_out);
    chk_pin("rd_wr", !wr, rd_wr);
    if (ar == 3'h2) chk_pin("row", a[25] ? 2'h1 : 2'h2, {row_strobe_high_half_n, row_strobe_low_half_n});
    chk_pin("rom_bank", rom ? 8'(~(8'h1 << a[25:23])) : 8'hFF, rom_bank_selects_n);
    @(posedge clk) #2;
    chk_pin("read_strobe", wr, read_strobe_n);
    if (ar == 3'h2) chk_pin("col", a[25] ? 2'h1 : 2'h2, {column_strobe_high_half_n, column_strobe_low_half_n});
    if (wr && !card) chk_pin("data_oe_hi", area_wide[ar], data_oe_hi);
    if (wr && card) chk_pin("card oe_hi", area_wide[ar] && !(io && little_endian && a[10]), data_oe_hi);
    if (wr && !card && area_wide[ar]) chk_pin("lanes", 4'(~be), lanes_n);
    if (card) begin
      chk_pin("enable2", {!(be[1] && !ar[0]), !(be[1] && ar[0])}, {slot_b_enable2_n, slot_a_enable2_n});
      chk_pin("card lanes", {!(wr && io), !(!wr && io), !(wr && !io)}, lanes_n[3:1]);
    end
  endtask : bus_op
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rst_n && cycle_start_out_n === 1'b0) starts++;
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) begin
        err_count++;
        $display("[ERR] rsp_valid expected 0 seen 1");
      end else begin
        n = notes.pop_front();
        if (n.chk) chk_data("rsp_rdata", n.d, rsp_rdata);
        chk_data("latency", n.lat, cyc);
        chk_data("starts", n.beats, starts);
        chk_pin("idle pins", 16'h3FF, {sels_n, lanes_n});
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    {rst_n, req_valid, req_write, req_io, req_addr, req_be, req_wdata, req_extra_beats, stall} = '0;
    {area0_burst_rom, area3_sdram, area6_pcmcia, sdram_clock_stop} = '0;
    {area2_sdram, area5_pcmcia, little_endian, bus_release_request_n} = 4'hF;
    area_wide = 7'h6F;
    rom_bank_enable = 2'h3;
    seed = 57;
    cyc = 0;
    repeat (10) @(posedge clk);
    #2 rst_n = 1'b1;
    for (int i = 0; i < 3; i++) bus_op(3'h0, 26'h100 + 26'(4 * i), 1'b1, 1'b0, 4'hF, 2'h0, 4'h0);
    for (int i = 0; i < 3; i++) bus_op(3'h0, 26'h100 + 26'(4 * i), 1'b0, 1'b0, 4'hF, 2'h0, 4'h0);
    bus_op(3'h0, 26'h100, 1'b0, 1'b0, 4'hF, 2'h2, 4'h0);
    bus_op(3'h0, 26'h104, 1'b0, 1'b0, 4'hF, 2'h0, 4'h3);
    bus_op(3'h0, 26'h2800000, 1'b1, 1'b0, 4'hF, 2'h0, 4'h0);
    bus_op(3'h3, 26'h40, 1'b1, 1'b0, 4'hF, 2'h0, 4'h0);
    for (int i = 0; i < 4; i++) begin
      bus_op(3'h3, 26'h40, 1'b1, 1'b0, 4'($random(seed)), 2'h0, 4'h0);
      bus_op(3'h3, 26'h40, 1'b0, 1'b0, 4'hF, 2'h0, 4'(i));
    end
    bus_op(3'h4, 26'h80, 1'b1, 1'b0, 4'hF, 2'h0, 4'h0);
    bus_op(3'h4, 26'h80, 1'b0, 1'b0, 4'hF, 2'h0, 4'h0);
    for (int i = 0; i < 2; i++) begin
      bus_op(3'h2, {i[0], 25'h200}, 1'b1, 1'b0, 4'hF, 2'h0, 4'h0);
      bus_op(3'h2, {i[0], 25'h200}, 1'b0, 1'b0, 4'hF, 2'h0, 4'h0);
    end
    for (int i = 0; i < 3; i++) bus_op(3'h5, 26'h300, i != 1, i > 0, 4'h3, 2'h0, 4'h0);
    bus_op(3'h6, 26'h20, 1'b0, 1'b0, 4'hF, 2'h0, 4'h0);
    for (int i = 0; i < 2; i++) begin
      little_endian = !i[0];
      bus_op(3'h5, 26'h700, 1'b1, 1'b1, 4'hF, 2'h0, 4'h0);
    end
    little_endian = 1'b1;
    area6_pcmcia = 1'b1;
    bus_op(3'h6, 26'h24, 1'b1, 1'b1, 4'h3, 2'h0, 4'h0);
    bus_release_request_n = 1'b0;
    for (int i = 0; i < 20 && bus_release_ack_n !== 1'b0; i++) @(posedge clk) #2;
    chk_pin("released oe", 16'h0, {req_ready, addr_oe, strobe_oe, data_oe_lo, bus_release_ack_n});
    bus_release_request_n = 1'b1;
    for (int i = 0; i < 5 && bus_release_ack_n !== 1'b1; i++) @(posedge clk) #2;
    chk_pin("oe after ack", 16'h0, addr_oe);
    @(posedge clk) #2;
    chk_pin("oe resumed", 16'h1, addr_oe);
    sdram_clock_stop = 1'b1;
    @(posedge clk) #2;
    chk_pin("clock enable", 16'h0, sdram_clock_enable);
    sdram_clock_stop = 1'b0;
    @(posedge clk) #2;
    chk_pin("clock enable", 16'h1, sdram_clock_enable);
    for (int i = 0; i < 40 && notes.size() > 0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk_data("pending notes", 32'h0, notes.size());
    tally_and_finish();
  end
endmodule : tb_external_memory_bus_pins
`default_nettype wire
